// ===== logic/lpd_ctrl.sv
/*
   lpd_ctrl: register file and duty generators for the white-LED switch,
   backlight pulse output, three-channel colour flasher and auxiliary
   open-drain pulse driver.
   Assumes the register port is driven by the serial slave on the same clock
   and the repetition-rate select level comes from logic on the same clock.
*/
// Functional notes
// - eight-bit codes give n/256 on fraction
// - zero white, backlight or colour code keeps output fully off
// - blink enable bit switches flashing
// - lit-time code selects lit interval
// - period code 1 s plus steps; F continuous
// - current field sets all three sinks
// - phase bit chooses out-of-phase channel
// - five-bit colour duty per channel
// - upper green/blue bits have no effect
// - aux enable bit gates pulse output
// - aux frequency code picks eight rates
// - aux duty is (code+1)/16
// - byte registers readable and writable at offsets
// - nonzero white duty starts boost soft-start
// - 256 whole pulses per repetition period
// - colour sinks only while blink enabled
// - colour repetition of 32 pulses
`timescale 1ns/1ps
module lpd_ctrl #(
   parameter int CLK_HZ_P         = lpd_pkg::CLK_HZ,
   parameter int PULSE_CYC_HI_P   = lpd_pkg::PULSE_CYC_HI,
   parameter int PULSE_CYC_LO_P   = lpd_pkg::PULSE_CYC_LO,
   parameter int BLINK_TICK_CYC_P = lpd_pkg::BLINK_TICK_CYC,
   parameter int TRI_PULSE_CYC_P  = lpd_pkg::TRI_PULSE_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   output logic      [7:0] reg_rdata,
   // rate select from the other register
   input  wire logic       repetition_rate_select,
   // white-LED boost
   output logic            white_led_switch,
   output logic            white_led_boost_en,
   output logic      [1:0] white_led_boost_step,
   // backlight
   output logic            backlight_pulse,
   // colour sinks
   output logic      [2:0] tricolor_sink_en,
   output logic      [1:0] tricolor_sink_current,
   // auxiliary open-drain pulse
   output logic            aux_pulse_o,
   output logic            aux_pulse_oe
);

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7-i];
      end
   endfunction

   function automatic logic [4:0] rev5(input logic [4:0] v);
      for (int i = 0; i < 5; i++) begin
         rev5[i] = v[4-i];
      end
   endfunction

   function automatic logic [23:0] aux_step_cyc(input logic [2:0] code);
      aux_step_cyc = 24'(CLK_HZ_P / (lpd_pkg::AUX_HZ[code] * lpd_pkg::AUX_STEPS));
   endfunction

   function automatic logic [7:0] lit_ticks(input logic [2:0] code);
      unique case (code)
         3'h5:    lit_ticks = 8'h08;
         3'h6:    lit_ticks = 8'h0A;
         3'h7:    lit_ticks = 8'h0C;
         default: lit_ticks = 8'(code) + 8'h02;
      endcase
   endfunction

   // register file
   lpd_pkg::lpd_regs_s regs_q, regs_d;
   logic [7:0]         rdata_q, rdata_d;

   always_comb begin
      regs_d = regs_q;
      if (reg_wr) begin
         unique case (reg_addr)
            lpd_pkg::ADDR_WHITE_DUTY: regs_d.white     = reg_wdata;
            lpd_pkg::ADDR_BLINK:      regs_d.blink     = reg_wdata;
            lpd_pkg::ADDR_RED:        regs_d.red       = reg_wdata;
            lpd_pkg::ADDR_GREEN:      regs_d.green     = reg_wdata;
            lpd_pkg::ADDR_BLUE:       regs_d.blue      = reg_wdata;
            lpd_pkg::ADDR_AUX:        regs_d.aux       = reg_wdata;
            lpd_pkg::ADDR_BACKLIGHT:  regs_d.backlight = reg_wdata;
            default:                  regs_d           = regs_q;
         endcase
      end
      unique case (reg_addr)
         lpd_pkg::ADDR_WHITE_DUTY: rdata_d = regs_q.white;
         lpd_pkg::ADDR_BLINK:      rdata_d = regs_q.blink;
         lpd_pkg::ADDR_RED:        rdata_d = regs_q.red;
         lpd_pkg::ADDR_GREEN:      rdata_d = regs_q.green;
         lpd_pkg::ADDR_BLUE:       rdata_d = regs_q.blue;
         lpd_pkg::ADDR_AUX:        rdata_d = regs_q.aux;
         lpd_pkg::ADDR_BACKLIGHT:  rdata_d = regs_q.backlight;
         default:                  rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regs_q  <= '{lpd_pkg::RST_WHITE_DUTY, lpd_pkg::RST_BLINK, lpd_pkg::RST_RED, lpd_pkg::RST_GREEN,
                      lpd_pkg::RST_BLUE, lpd_pkg::RST_AUX, lpd_pkg::RST_BACKLIGHT};
         rdata_q <= 8'h00;
      end else begin
         regs_q  <= regs_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // white-LED and backlight repetition, with boost soft-start
   logic [11:0]         bl_cnt_q, bl_cnt_d;
   logic [7:0]          bl_idx_q, bl_idx_d;
   logic [7:0]          white_ap_q, white_ap_d;
   logic [7:0]          back_ap_q, back_ap_d;
   logic                rate_ap_q, rate_ap_d;
   logic                white_sw_q, white_sw_d;
   logic                back_q, back_d;
   lpd_pkg::lpd_boost_e bst_q, bst_d;
   logic                bl_pulse_end, bl_rep_end;

   always_comb begin
      bl_pulse_end = bl_cnt_q == (rate_ap_q ? 12'(PULSE_CYC_HI_P - 1) : 12'(PULSE_CYC_LO_P - 1));
      bl_rep_end   = bl_pulse_end && (bl_idx_q == 8'hFF);
      bl_cnt_d     = bl_pulse_end ? 12'h000 : bl_cnt_q + 12'h001;
      bl_idx_d     = bl_pulse_end ? bl_idx_q + 8'h01 : bl_idx_q;
      white_ap_d   = bl_rep_end ? regs_q.white : white_ap_q;
      back_ap_d    = bl_rep_end ? regs_q.backlight : back_ap_q;
      rate_ap_d    = bl_rep_end ? repetition_rate_select : rate_ap_q;
      // each pulse is wholly on or off; a reversed index spreads them evenly
      white_sw_d   = (bst_q != lpd_pkg::BST_OFF) && (rev8(bl_idx_d) < white_ap_d);
      back_d       = rev8(bl_idx_d) < back_ap_d;
      bst_d        = bst_q;
      if (white_ap_d == 8'h00) begin
         bst_d = lpd_pkg::BST_OFF;
      end else if (bst_q == lpd_pkg::BST_OFF) begin
         bst_d = lpd_pkg::BST_I125;
      end else if (bl_rep_end) begin
         unique case (bst_q)
            lpd_pkg::BST_I125: bst_d = lpd_pkg::BST_I250;
            lpd_pkg::BST_I250: bst_d = lpd_pkg::BST_RUN;
            lpd_pkg::BST_RUN:  bst_d = lpd_pkg::BST_RUN;
            default:           bst_d = lpd_pkg::BST_OFF;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bl_cnt_q   <= 12'h000;
         bl_idx_q   <= 8'h00;
         white_ap_q <= lpd_pkg::RST_WHITE_DUTY;
         back_ap_q  <= lpd_pkg::RST_BACKLIGHT;
         rate_ap_q  <= 1'b0;
         white_sw_q <= 1'b0;
         back_q     <= 1'b0;
         bst_q      <= lpd_pkg::BST_OFF;
      end else begin
         bl_cnt_q   <= bl_cnt_d;
         bl_idx_q   <= bl_idx_d;
         white_ap_q <= white_ap_d;
         back_ap_q  <= back_ap_d;
         rate_ap_q  <= rate_ap_d;
         white_sw_q <= white_sw_d;
         back_q     <= back_d;
         bst_q      <= bst_d;
      end
   end

   assign white_led_switch     = white_sw_q;
   assign white_led_boost_en   = bst_q != lpd_pkg::BST_OFF;
   assign white_led_boost_step = bst_q;
   assign backlight_pulse      = back_q;

   // colour duty and blink timing
   logic [15:0] tri_cnt_q, tri_cnt_d;
   logic [4:0]  tri_idx_q, tri_idx_d;
   logic [14:0] tri_ap_q, tri_ap_d;
   logic [23:0] tick_cnt_q, tick_cnt_d;
   logic [7:0]  pos_q, pos_d;
   logic [7:0]  blink_ap_q, blink_ap_d;
   logic [2:0]  sink_q, sink_d;
   logic        tri_end, tick, blink_en;
   logic [7:0]  per_ticks, half, on_t;
   logic        lit_in, lit_out, pha;
   logic [2:0]  pw;

   always_comb begin
      blink_en   = regs_q.blink[lpd_pkg::BLINK_EN_BIT];
      tri_end    = tri_cnt_q == 16'(TRI_PULSE_CYC_P - 1);
      tri_cnt_d  = tri_end ? 16'h0000 : tri_cnt_q + 16'h0001;
      tri_idx_d  = tri_end ? tri_idx_q + 5'h01 : tri_idx_q;
      // only the low five bits of each colour register are taken
      tri_ap_d   = (tri_end && tri_idx_q == 5'h1F)
                   ? {regs_q.red[4:0], regs_q.green[4:0], regs_q.blue[4:0]} : tri_ap_q;
      per_ticks  = 8'(lpd_pkg::BLINK_PER_BASE)
                   + 8'(lpd_pkg::BLINK_PER_STEP) * 8'(blink_ap_q[lpd_pkg::BLINK_PER_LSB +: 4]);
      half       = per_ticks >> 1;
      on_t       = lit_ticks(blink_ap_q[lpd_pkg::BLINK_LIT_LSB +: 3]);
      tick       = tick_cnt_q == 24'(BLINK_TICK_CYC_P - 1);
      tick_cnt_d = (!blink_en || tick) ? 24'h000000 : tick_cnt_q + 24'h000001;
      pos_d      = pos_q;
      blink_ap_d = blink_ap_q;
      if (!blink_en) begin
         pos_d      = 8'h00;
         blink_ap_d = regs_q.blink;
      end else if (tick) begin
         if (pos_q >= per_ticks - 8'h01) begin
            pos_d      = 8'h00;
            blink_ap_d = regs_q.blink;
         end else begin
            pos_d = pos_q + 8'h01;
         end
      end
      if (blink_ap_q[lpd_pkg::BLINK_PER_LSB +: 4] == lpd_pkg::BLINK_CONT) begin
         lit_in  = 1'b1;
         lit_out = 1'b1;
      end else begin
         lit_in  = pos_q < on_t;
         lit_out = (pos_q >= half) && (pos_q < half + on_t);
      end
      pha    = regs_q.red[lpd_pkg::RED_PHASE_BIT];
      pw[2]  = rev5(tri_idx_d) < tri_ap_d[14:10];
      pw[1]  = rev5(pha ? tri_idx_d : tri_idx_d ^ 5'h10) < tri_ap_d[9:5];
      pw[0]  = rev5(pha ? tri_idx_d ^ 5'h10 : tri_idx_d) < tri_ap_d[4:0];
      sink_d = {pw[2] && lit_in, pw[1] && (pha ? lit_in : lit_out), pw[0] && (pha ? lit_out : lit_in)};
      if (!blink_en) begin
         sink_d = 3'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tri_cnt_q  <= 16'h0000;
         tri_idx_q  <= 5'h00;
         tri_ap_q   <= 15'h0000;
         tick_cnt_q <= 24'h000000;
         pos_q      <= 8'h00;
         blink_ap_q <= lpd_pkg::RST_BLINK;
         sink_q     <= 3'h0;
      end else begin
         tri_cnt_q  <= tri_cnt_d;
         tri_idx_q  <= tri_idx_d;
         tri_ap_q   <= tri_ap_d;
         tick_cnt_q <= tick_cnt_d;
         pos_q      <= pos_d;
         blink_ap_q <= blink_ap_d;
         sink_q     <= sink_d;
      end
   end

   assign tricolor_sink_en      = sink_q;
   assign tricolor_sink_current = regs_q.red[lpd_pkg::RED_ISET_LSB +: 2];

   // auxiliary open-drain pulse; pulls low while on
   logic [23:0] aux_cnt_q, aux_cnt_d;
   logic [3:0]  aux_idx_q, aux_idx_d;
   logic [7:0]  aux_ap_q, aux_ap_d;
   logic        aux_on_q, aux_on_d;
   logic        aux_step_end, aux_per_end;

   always_comb begin
      aux_step_end = aux_cnt_q >= aux_step_cyc(aux_ap_q[lpd_pkg::AUX_FREQ_LSB +: 3]) - 24'h000001;
      aux_per_end  = aux_step_end && (aux_idx_q == 4'hF);
      aux_cnt_d    = aux_step_end ? 24'h000000 : aux_cnt_q + 24'h000001;
      aux_idx_d    = aux_step_end ? aux_idx_q + 4'h1 : aux_idx_q;
      aux_ap_d     = (aux_per_end || !aux_ap_q[lpd_pkg::AUX_EN_BIT]) ? regs_q.aux : aux_ap_q;
      aux_on_d     = aux_ap_d[lpd_pkg::AUX_EN_BIT]
                     && (aux_idx_d <= aux_ap_d[lpd_pkg::AUX_DUTY_LSB +: 4]);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aux_cnt_q <= 24'h000000;
         aux_idx_q <= 4'h0;
         aux_ap_q  <= lpd_pkg::RST_AUX;
         aux_on_q  <= 1'b0;
      end else begin
         aux_cnt_q <= aux_cnt_d;
         aux_idx_q <= aux_idx_d;
         aux_ap_q  <= aux_ap_d;
         aux_on_q  <= aux_on_d;
      end
   end

   assign aux_pulse_o  = 1'b0;
   assign aux_pulse_oe = aux_on_q;

   // checks
   zero_white_off_a: assert property (@(posedge clk) disable iff (!resetn)
      (white_ap_q == 8'h00) |=> !white_led_switch) else $error("white switch on with zero duty");
   zero_back_off_a: assert property (@(posedge clk) disable iff (!resetn)
      (back_ap_d == 8'h00) |=> !backlight_pulse) else $error("backlight on with zero duty");
   full_back_on_a: assert property (@(posedge clk) disable iff (!resetn)
      (back_ap_d == 8'hFF && bl_idx_d != 8'hFF) |=> backlight_pulse)
      else $error("backlight off at full code");
   boost_start_a: assert property (@(posedge clk) disable iff (!resetn)
      (bst_q == lpd_pkg::BST_OFF && white_ap_d != 8'h00) |=> bst_q == lpd_pkg::BST_I125)
      else $error("boost did not start soft-start");
   boost_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (bst_q == lpd_pkg::BST_I125 && !bl_rep_end && white_ap_d != 8'h00) |=> $stable(bst_q))
      else $error("soft-start step left early");
   sink_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      !regs_q.blink[lpd_pkg::BLINK_EN_BIT] |=> tricolor_sink_en == 3'h0) else $error("sink on while disabled");
   sink_cur_a: assert property (@(posedge clk) disable iff (!resetn)
      tricolor_sink_current == regs_q.red[7:6]) else $error("sink current mismatch");
   aux_off_a: assert property (@(posedge clk) disable iff (!resetn)
      (!regs_q.aux[lpd_pkg::AUX_EN_BIT] && !aux_ap_q[lpd_pkg::AUX_EN_BIT]) |=> !aux_pulse_oe)
      else $error("aux pulse while disabled");
   aux_full_a: assert property (@(posedge clk) disable iff (!resetn)
      (aux_ap_q[7] && aux_ap_q[3:0] == 4'hF && !aux_per_end) |=> aux_pulse_oe) else $error("aux not full-on");
   readback_a: assert property (@(posedge clk) disable iff (!resetn)
      (reg_wr && reg_addr == lpd_pkg::ADDR_BLUE) ##1 (!reg_wr && reg_addr == lpd_pkg::ADDR_BLUE)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("register readback mismatch");

   boost_run_c: cover property (@(posedge clk) disable iff (!resetn) bst_q == lpd_pkg::BST_RUN);
   blink_lit_c: cover property (@(posedge clk) disable iff (!resetn) tricolor_sink_en != 3'h0);
   aux_pulse_c: cover property (@(posedge clk) disable iff (!resetn) $rose(aux_pulse_oe));
   back_pulse_c: cover property (@(posedge clk) disable iff (!resetn) $fell(backlight_pulse));

endmodule

// ===== logic/lpd_pkg.sv
/*
   lpd_pkg: register map, reset values, field layouts, timing constants and
   carrier types for the LED and pulse duty controller.
   Assumes a single 125 MHz clock and a byte-wide register port fed by the
   serial control slave.
*/
package lpd_pkg;

   // register offsets
   localparam logic [7:0] ADDR_WHITE_DUTY  = 8'h16;
   localparam logic [7:0] ADDR_BLINK       = 8'h17;
   localparam logic [7:0] ADDR_RED         = 8'h18;
   localparam logic [7:0] ADDR_GREEN       = 8'h19;
   localparam logic [7:0] ADDR_BLUE        = 8'h1A;
   localparam logic [7:0] ADDR_AUX         = 8'h1D;
   localparam logic [7:0] ADDR_BACKLIGHT   = 8'h27;

   // values after reset
   localparam logic [7:0] RST_WHITE_DUTY   = 8'h00;
   localparam logic [7:0] RST_BLINK        = 8'h00;
   localparam logic [7:0] RST_RED          = 8'h00;
   localparam logic [7:0] RST_GREEN        = 8'h00;
   localparam logic [7:0] RST_BLUE         = 8'h00;
   localparam logic [7:0] RST_AUX          = 8'h00;
   localparam logic [7:0] RST_BACKLIGHT    = 8'h00;

   // field positions
   localparam int BLINK_EN_BIT     = 7;
   localparam int BLINK_LIT_LSB    = 4;
   localparam int BLINK_PER_LSB    = 0;
   localparam int RED_ISET_LSB     = 6;
   localparam int RED_PHASE_BIT    = 5;
   localparam int AUX_EN_BIT       = 7;
   localparam int AUX_FREQ_LSB     = 4;
   localparam int AUX_DUTY_LSB     = 0;

   // timing
   localparam int    CLK_HZ          = 125_000_000;
   localparam int    REP_HZ_HI       = 180;
   localparam int    REP_HZ_LO       = 122;
   localparam int    REP_PULSES      = 256;
   localparam int    PULSE_CYC_HI    = CLK_HZ / (REP_HZ_HI * REP_PULSES);
   localparam int    PULSE_CYC_LO    = CLK_HZ / (REP_HZ_LO * REP_PULSES);
   localparam int    TRI_PULSES      = 32;
   localparam int    TRI_REP_HZ      = 200;
   localparam int    TRI_PULSE_CYC   = CLK_HZ / (TRI_REP_HZ * TRI_PULSES);
   localparam int    BLINK_TICK_MS   = 50;
   localparam int    BLINK_TICK_CYC  = (CLK_HZ / 1000) * BLINK_TICK_MS;
   localparam int    BLINK_PER_BASE  = 20;
   localparam int    BLINK_PER_STEP  = 10;
   localparam logic [3:0] BLINK_CONT  = 4'hF;
   localparam int    AUX_STEPS       = 16;
   localparam int    AUX_HZ [8]      = '{15600, 7800, 4500, 3000, 2000, 1500, 1000, 500};

   // soft-start steps, gray along the path
   typedef enum logic [1:0] {
      BST_OFF  = 2'b00,
      BST_I125 = 2'b01,
      BST_I250 = 2'b11,
      BST_RUN  = 2'b10
   } lpd_boost_e;

   typedef struct packed {
      logic [7:0] white;
      logic [7:0] blink;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic [7:0] aux;
      logic [7:0] backlight;
   } lpd_regs_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } lpd_wr_s;

endpackage

// ===== tb/lpd_load_model.sv
/*
   lpd_load_model: loads on the controller outputs. It counts the cycles each
   load is energised, times red blink bursts and resolves the open-drain pin.
   Assumes the controller clock and a counter-clear strobe from the bench.
*/
`timescale 1ns/1ps
module lpd_load_model (
   // clock and bench control
   input  wire logic       clk,
   input  wire logic       clr,
   // controller outputs
   input  wire logic [2:0] sink_en,
   input  wire logic       lamp_on,
   input  wire logic       od_o,
   input  wire logic       od_oe,
   // observations
   output logic            od_pin,
   output int              cnt [7],
   output int              burst_per,
   output int              burst_len
);
   int t       = 0;
   int start   = 0;
   int last_on = 0;
   int off_run = 0;

   // pull-up holds the pin high once released
   assign od_pin = od_oe ? od_o : 1'b1;

   always @(posedge clk) begin
      t <= t + 1;
      if (clr) begin
         cnt <= '{default: 0};
      end else begin
         cnt[0] <= cnt[0] + int'(sink_en[2]);
         cnt[1] <= cnt[1] + int'(sink_en[1]);
         cnt[2] <= cnt[2] + int'(sink_en[0]);
         cnt[3] <= cnt[3] + int'(sink_en[2] & sink_en[1]);
         cnt[4] <= cnt[4] + int'(sink_en[2] & sink_en[0]);
         cnt[5] <= cnt[5] + int'(od_pin == 1'b0);
         cnt[6] <= cnt[6] + int'(lamp_on);
      end
      // a red burst starts after a long dark gap
      if (sink_en[2]) begin
         if (off_run >= 30) begin
            burst_per <= t - start;
            burst_len <= last_on - start + 1;
            start     <= t;
         end
         last_on <= t;
         off_run <= 0;
      end else begin
         off_run <= off_run + 1;
      end
   end
endmodule

// ===== tb/lpd_ctrl_tb.sv
/*
   lpd_ctrl_tb: self-checking bench for the LED and pulse duty controller.
   Assumes short tick parameters so blink, colour and aux timing fit the run.
*/
`timescale 1ns/1ps
module lpd_ctrl_tb;
   localparam int CLK_P  = 1_000_000;
   localparam int TICK_P = 10;
   localparam int TPC_P  = 4;
   localparam int PCH_P  = 2;
   localparam int PCL_P  = 3;

   logic       clk       = 1'b0;
   logic       resetn    = 1'b0;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       clr       = 1'b0;
   logic       rate_sel  = 1'b1;
   logic [1:0] lamp_sel  = 2'h0;
   logic [7:0] reg_rdata;
   logic       white_sw;
   logic       boost_en;
   logic [1:0] boost_step;
   logic       bl;
   logic [2:0] sink_en;
   logic [1:0] sink_cur;
   logic       aux_o;
   logic       aux_oe;
   logic       od_pin;
   int         cnt [7];
   int         burst_per;
   int         burst_len;
   int         error_cnt = 0;
   int         compares  = 0;

   always #4 clk = ~clk;

   lpd_ctrl #(.CLK_HZ_P(CLK_P), .PULSE_CYC_HI_P(PCH_P), .PULSE_CYC_LO_P(PCL_P), .BLINK_TICK_CYC_P(TICK_P),
              .TRI_PULSE_CYC_P(TPC_P)) dut_u (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rdata(reg_rdata), .repetition_rate_select(rate_sel), .white_led_switch(white_sw),
      .white_led_boost_en(boost_en), .white_led_boost_step(boost_step), .backlight_pulse(bl),
      .tricolor_sink_en(sink_en), .tricolor_sink_current(sink_cur), .aux_pulse_o(aux_o),
      .aux_pulse_oe(aux_oe));

   lpd_load_model load_u (
      .clk(clk), .clr(clr), .sink_en(sink_en),
      .lamp_on((lamp_sel == 2'h0) ? bl : ((lamp_sel == 2'h1) ? white_sw : (bl | white_sw | boost_en))),
      .od_o(aux_o),
      .od_oe(aux_oe), .od_pin(od_pin), .cnt(cnt), .burst_per(burst_per), .burst_len(burst_len));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   task automatic near(input string nm, input int exp, input int got);
      compares++;
      if (got < exp - TPC_P || got > exp + TPC_P) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      repeat (2) @(negedge clk);
      chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
   endtask

   // clear the load counters, then let n cycles be counted
   task automatic span(input int n);
      @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      repeat (n) @(negedge clk);
   endtask

   task automatic t_regs;
      logic [7:0] a [8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1D, 8'h27, 8'h20};
      chk("outputs", 32'h0, {24'h0, bl, white_sw, boost_step, sink_en, aux_oe});
      for (int i = 0; i < 8; i++) rd(a[i], 8'h00);
      for (int i = 0; i < 8; i++) wr(a[i], 8'hA0 + 8'(i));
      for (int i = 0; i < 8; i++) rd(a[i], (i == 7) ? 8'h00 : 8'hA0 + 8'(i));
      chk("sink_current", 32'h2, {30'h0, sink_cur});
      wr(8'h18, 8'hC0);
      repeat (3) @(negedge clk);
      chk("sink_current", 32'h3, {30'h0, sink_cur});
      for (int i = 0; i < 7; i++) wr(a[i], 8'h00);
   endtask

   task automatic t_colour;
      wr(8'h17, 8'h8F);
      wr(8'h18, 8'h1F);
      wr(8'h19, 8'hF0);
      wr(8'h1A, 8'h00);
      repeat (512) @(negedge clk);
      span(32 * TPC_P * 10);
      chk("red_on", 31 * TPC_P * 10, cnt[0]);
      chk("green_on", 16 * TPC_P * 10, cnt[1]);
      chk("blue_on", 0, cnt[2]);
      wr(8'h17, 8'h0F);
      repeat (20) @(negedge clk);
      span(500);
      chk("sinks_disabled", 0, cnt[0] + cnt[1] + cnt[2]);
   endtask

   task automatic t_phase;
      logic [7:0] r [2] = '{8'h1F, 8'h3F};
      wr(8'h17, 8'h80);
      wr(8'h19, 8'h1F);
      wr(8'h1A, 8'h1F);
      for (int p = 0; p < 2; p++) begin
         wr(8'h18, r[p]);
         // the continuous setting left from the colour test runs one long period first
         repeat ((p == 0) ? 2400 : 600) @(negedge clk);
         span(2000);
         chk("red_green_overlap", 32'(p), 32'(cnt[3] > 0));
         chk("red_blue_overlap", 32'(1 - p), 32'(cnt[4] > 0));
      end
   endtask

   task automatic t_blink;
      logic [7:0] v [3] = '{8'h80, 8'hD3, 8'hFE};
      int         per;
      int         lc;
      wr(8'h18, 8'h1F);
      wr(8'h19, 8'h00);
      wr(8'h1A, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(8'h17, v[i]);
         per = (20 + 10 * int'(v[i][3:0])) * TICK_P;
         lc  = int'(v[i][6:4]);
         repeat (3 * per + 200) @(negedge clk);
         near("blink_period", per, burst_per);
         near("blink_lit", ((lc < 5) ? 2 + lc : 2 * lc - 2) * TICK_P, burst_len);
      end
      wr(8'h17, 8'h00);
   endtask

   task automatic t_aux;
      int f;
      int d;
      int step;
      for (int k = 0; k < 10; k++) begin
         f    = (k < 8) ? k : 0;
         d    = (k < 8) ? 3 : ((k == 8) ? 0 : 15);
         step = CLK_P / (lpd_pkg::AUX_HZ[f] * 16);
         wr(8'h1D, {1'b1, 3'(f), 4'(d)});
         repeat (2100) @(negedge clk);
         span(4 * 16 * step);
         chk("aux_low_cycles", 32'(4 * (d + 1) * step), 32'(cnt[5]));
      end
      wr(8'h1D, 8'h0F);
      repeat (300) @(negedge clk);
      span(300);
      chk("aux_disabled", 0, cnt[5]);
      chk("aux_pin", 32'h1, {31'h0, od_pin});
   endtask

   // white switch at the fast repetition rate and backlight at both rates, then both back off
   task automatic t_lamps;
      wr(8'h27, 8'hFF);
      wr(8'h16, 8'h80);
      repeat (4 * 256 * PCH_P) @(negedge clk);
      chk("boost_step", 32'h2, {30'h0, boost_step});
      lamp_sel = 2'h0;
      span(4 * 256 * PCH_P);
      chk("backlight_on", 32'(4 * 255 * PCH_P), 32'(cnt[6]));
      lamp_sel = 2'h1;
      span(4 * 256 * PCH_P);
      chk("white_on", 32'(4 * 128 * PCH_P), 32'(cnt[6]));
      rate_sel = 1'b0;
      lamp_sel = 2'h0;
      repeat (3 * 256 * PCH_P) @(negedge clk);
      span(4 * 256 * PCL_P);
      chk("backlight_slow", 32'(4 * 255 * PCL_P), 32'(cnt[6]));
      wr(8'h16, 8'h00);
      wr(8'h27, 8'h00);
      lamp_sel = 2'h2;
      repeat (2 * 256 * PCL_P) @(negedge clk);
      span(3000);
      chk("white_backlight_off", 0, cnt[6]);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90_000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      t_regs();
      t_colour();
      t_phase();
      t_blink();
      t_aux();
      t_lamps();
      end_sim();
   end
endmodule
